// [rtl/cab_consts.svh]
/*
  Constants of the consecutive-event qualifier.
  Assumes inclusion by bare name.
*/
`ifndef CAB_CONSTS_SVH
`define CAB_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices and byte addresses (byte address = 4 * index)
// ----------------------------------------------------------------------
`define CAB_IDX_COUNT_CTRL 8'h22
`define CAB_IDX_EXT1_COMP 8'h25
`define CAB_IDX_EXT2_COMP 8'h26
`define CAB_IDX_MODE_CTRL 8'h40
`define CAB_IDX_HYSTERESIS 8'h41
`define CAB_IDX_STATUS 8'h42
`define CAB_ADDR_W 12
`define CAB_ADDR_COUNT_CTRL 12'h088
`define CAB_ADDR_EXT1_COMP 12'h094
`define CAB_ADDR_EXT2_COMP 12'h098
`define CAB_ADDR_MODE_CTRL 12'h100
`define CAB_ADDR_HYSTERESIS 12'h104
`define CAB_ADDR_STATUS 12'h108

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CAB_TIMEOUT_BIT 7
`define CAB_CRIT_LSB 4
`define CAB_EVENT_LSB 1
`define CAB_AUTO_BIT 3
`define CAB_STAT_OVER_LSB 0
`define CAB_STAT_UNDER_LSB 8
`define CAB_STAT_FAULT_LSB 16
`define CAB_STAT_ALERT_BIT 24
`define CAB_STAT_CRIT_BIT 25

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CAB_RST_COUNT_CTRL 8'h70
`define CAB_RST_EXT1_COMP 8'h08
`define CAB_RST_EXT2_COMP 8'h08
`define CAB_RST_HYSTERESIS 8'h0a

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CAB_TIMEOUT_MS 30
`define CAB_CLK_HZ 10000000
`define CAB_TIMEOUT_CYCLES ((`CAB_TIMEOUT_MS * `CAB_CLK_HZ) / 1000)

`endif

// [rtl/cab_pkg.sv]
/*
  Types shared by the consecutive-event qualifier.
  Assumes nothing of its surroundings.
*/
package cab_pkg;

  // behaviour of the event output
  typedef enum logic [0:0]
  {
    CAB_MODE_INTERRUPT = 1'b0,
    CAB_MODE_COMPARATOR = 1'b1
  } cab_alert_mode_t;

  // axi response codes
  typedef enum logic [1:0]
  {
    CAB_RESP_OKAY = 2'b00,
    CAB_RESP_SLVERR = 2'b10
  } cab_resp_t;

endpackage : cab_pkg

// [rtl/cab_chan_qual.sv]
/*
  One channel's event and critical consecutive counters.
  Assumes a one-cycle same-clock meas_done, with the data valid then.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cab_consts.svh"

module cab_chan_qual (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic meas_done,
  input wire cab_pkg::cab_alert_mode_t mode,
  input wire logic [7:0] temp,
  input wire logic [7:0] high_limit,
  input wire logic [7:0] low_limit,
  input wire logic [7:0] crit_limit,
  input wire logic fault,
  input wire logic [7:0] hysteresis,
  input wire logic [2:0] event_need,
  input wire logic [2:0] crit_need,
  output logic ev_fire,
  output logic ev_over,
  output logic ev_under,
  output logic ev_fault,
  output logic ev_held,
  output logic crit_held
);

  // ----------------------------------------------------------------------
  // comparisons
  // ----------------------------------------------------------------------

  // true when the reading lies below limit minus hysteresis
  function automatic logic below_hyst(input logic [7:0] t, input logic [7:0] h,
                                      input logic [7:0] lim);
    logic [8:0] sum;
    sum = {1'b0, t} + {1'b0, h};
    return sum < {1'b0, lim};
  endfunction : below_hyst

  logic is_over;
  logic is_under;
  logic is_crit;
  logic [2:0] ev_cnt;
  logic [2:0] crit_cnt;
  logic [2:0] next_ev_cnt;
  logic [2:0] next_crit_cnt;

  assign is_over = temp > high_limit;
  assign is_under = temp <= low_limit;
  assign is_crit = temp > crit_limit;
  assign next_ev_cnt = ev_cnt + 3'h1;
  assign next_crit_cnt = crit_cnt + 3'h1;

  // ----------------------------------------------------------------------
  // event counter
  // ----------------------------------------------------------------------

  // counts back-to-back bad readings, fires when the shared count is met
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_cnt <= 3'h0;
      ev_held <= 1'b0;
      ev_fire <= 1'b0;
      ev_over <= 1'b0;
      ev_under <= 1'b0;
      ev_fault <= 1'b0;
    end
    else if (ce)
    begin
      ev_fire <= 1'b0;
      if (meas_done)
      begin
        if (mode == cab_pkg::CAB_MODE_COMPARATOR)
        begin
          ev_under <= 1'b0;
          ev_fault <= 1'b0;
          ev_over <= is_over;
          if (ev_held)
          begin
            if (below_hyst(temp, hysteresis, high_limit))
            begin
              ev_held <= 1'b0;
              ev_cnt <= 3'h0;
            end
          end
          else if (is_over)
          begin
            ev_cnt <= next_ev_cnt;
            if (next_ev_cnt >= event_need)
            begin
              ev_held <= 1'b1;
              ev_fire <= 1'b1;
            end
          end
          else
          begin
            ev_cnt <= 3'h0;
          end
        end
        else
        begin
          ev_held <= 1'b0;
          ev_over <= is_over;
          ev_under <= is_under;
          ev_fault <= fault;
          if (is_over || is_under || fault)
          begin
            if (next_ev_cnt >= event_need)
            begin
              ev_fire <= 1'b1;
              ev_cnt <= 3'h0;
            end
            else
            begin
              ev_cnt <= next_ev_cnt;
            end
          end
          else
          begin
            ev_cnt <= 3'h0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // critical counter
  // ----------------------------------------------------------------------

  // latches once the count is met, released only below limit minus hysteresis
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      crit_cnt <= 3'h0;
      crit_held <= 1'b0;
    end
    else if (ce && meas_done)
    begin
      if (crit_held)
      begin
        if (below_hyst(temp, hysteresis, crit_limit))
        begin
          crit_held <= 1'b0;
          crit_cnt <= 3'h0;
        end
      end
      else if (is_crit)
      begin
        crit_cnt <= next_crit_cnt;
        if (next_crit_cnt >= crit_need)
        begin
          crit_held <= 1'b1;
        end
      end
      else
      begin
        crit_cnt <= 3'h0;
      end
    end
  end

endmodule : cab_chan_qual

`default_nettype wire

// [rtl/cab_top.sv]
/*
  Consecutive-event qualifier with compensation-factor configuration and
  bus stall timeout, reached over AXI4-Lite.
  Assumes measurement strobes and channel data come from same-clock logic,
  and the serial clock pin arrives from outside the clock domain.
*/
// Register access over AXI4-Lite was decided locally.
//
// Overview of operation
// - repeated bad readings bump channel event counter
// - clean reading clears channel event counter
// - interrupt mode: flag status, assert pin, restart
// - comparator mode counts only over-high readings
// - comparator mode holds until below high minus hysteresis
// - timeout bit enables 30 ms clock-low reset
// - critical count sets readings before critical pin
// - critical counter resets at or below limit before assertion
// - after assertion, hold until below hysteresis point
// - event count sets readings before event pin
// - count codes decode to one through four
// - count register resets to 70h
// - one counter pair per channel, shared thresholds
// - autodetect picks factor each conversion start
// - factor reads in-use value, writes ignored if auto
// - 7h disables compensation, 8h-Fh selects autodetect
// - first channel config resets to 08h
`timescale 1ns/1ps
`default_nettype none
`include "cab_consts.svh"

module cab_top #(
  parameter int NCH = 3,
  parameter int TIMEOUT_CYCLES = `CAB_TIMEOUT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [`CAB_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`CAB_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic [NCH*8-1:0] ch_temp,
  input wire logic [NCH*8-1:0] ch_high_limit,
  input wire logic [NCH*8-1:0] ch_low_limit,
  input wire logic [NCH*8-1:0] ch_crit_limit,
  input wire logic [NCH-1:0] ch_fault,
  input wire logic [2:0] ext1_auto_factor,
  input wire logic [2:0] ext2_auto_factor,
  input wire logic smclk_pin,
  output logic smbus_proto_reset,
  output logic alert_n,
  output logic crit_n,
  output logic [3:0] ext1_comp_setting,
  output logic [3:0] ext2_comp_setting
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // repeat-count code to number of readings; 000,001,011,111 give 1..4
  function automatic logic [2:0] count_decode(input logic [2:0] code);
    return 3'(code[0]) + 3'(code[1]) + 3'(code[2]) + 3'h1;
  endfunction : count_decode

  // true for every register address that answers OKAY
  function automatic logic is_mapped(input logic [`CAB_ADDR_W-1:0] a);
    return a == `CAB_ADDR_COUNT_CTRL || a == `CAB_ADDR_EXT1_COMP ||
           a == `CAB_ADDR_EXT2_COMP || a == `CAB_ADDR_MODE_CTRL ||
           a == `CAB_ADDR_HYSTERESIS || a == `CAB_ADDR_STATUS;
  endfunction : is_mapped

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic timeout_en;
  logic [2:0] critical_repeat_count;
  logic [2:0] event_repeat_count;
  logic ext1_factor_autodetect_on;
  logic [2:0] ext1_compensation_factor_setting;
  logic ext2_factor_autodetect_on;
  logic [2:0] ext2_compensation_factor_setting;
  cab_pkg::cab_alert_mode_t alert_mode;
  logic [7:0] hysteresis;
  logic [NCH-1:0] stat_over;
  logic [NCH-1:0] stat_under;
  logic [NCH-1:0] stat_fault;

  // write channel holding registers
  logic [`CAB_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic wr_lane0;
  logic [31:0] lane_mask;

  // per-channel results
  logic [NCH-1:0] ev_fire;
  logic [NCH-1:0] ev_over;
  logic [NCH-1:0] ev_under;
  logic [NCH-1:0] ev_fault;
  logic [NCH-1:0] ev_held;
  logic [NCH-1:0] crit_held;
  logic [NCH-1:0] next_stat_over;
  logic [NCH-1:0] next_stat_under;
  logic [NCH-1:0] next_stat_fault;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------------
  // axi write path
  // ----------------------------------------------------------------------

  // address and data taken in either order, response once both are held
  assign do_write = !awready && !wready && !bvalid;
  assign wr_lane0 = do_write && w_strb_q[0];
  assign lane_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
                      {8{w_strb_q[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= cab_pkg::CAB_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_addr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready <= 1'b0;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= is_mapped(aw_addr_q) ? cab_pkg::CAB_RESP_OKAY : cab_pkg::CAB_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi read path
  // ----------------------------------------------------------------------

  // read mux; unused bits of every register read zero
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (araddr)
      `CAB_ADDR_COUNT_CTRL:
      begin
        rd_mux[`CAB_TIMEOUT_BIT] = timeout_en;
        rd_mux[`CAB_CRIT_LSB +: 3] = critical_repeat_count;
        rd_mux[`CAB_EVENT_LSB +: 3] = event_repeat_count;
      end
      `CAB_ADDR_EXT1_COMP:
        rd_mux[3:0] = ext1_comp_setting;
      `CAB_ADDR_EXT2_COMP:
        rd_mux[3:0] = ext2_comp_setting;
      `CAB_ADDR_MODE_CTRL:
        rd_mux[0] = alert_mode;
      `CAB_ADDR_HYSTERESIS:
        rd_mux[7:0] = hysteresis;
      `CAB_ADDR_STATUS:
      begin
        rd_mux[`CAB_STAT_OVER_LSB +: NCH] = stat_over;
        rd_mux[`CAB_STAT_UNDER_LSB +: NCH] = stat_under;
        rd_mux[`CAB_STAT_FAULT_LSB +: NCH] = stat_fault;
        rd_mux[`CAB_STAT_ALERT_BIT] = !alert_n;
        rd_mux[`CAB_STAT_CRIT_BIT] = !crit_n;
      end
      default:
        rd_mux = 32'h0;
    endcase
  end

  // one read at a time, answered the cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= cab_pkg::CAB_RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= is_mapped(araddr) ? cab_pkg::CAB_RESP_OKAY : cab_pkg::CAB_RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------

  // repeat counts and timeout enable; bit 0 is not stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timeout_en <= 1'(`CAB_RST_COUNT_CTRL >> `CAB_TIMEOUT_BIT);
      critical_repeat_count <= 3'(`CAB_RST_COUNT_CTRL >> `CAB_CRIT_LSB);
      event_repeat_count <= 3'(`CAB_RST_COUNT_CTRL >> `CAB_EVENT_LSB);
    end
    else if (ce && wr_lane0 && aw_addr_q == `CAB_ADDR_COUNT_CTRL)
    begin
      timeout_en <= w_data_q[`CAB_TIMEOUT_BIT];
      critical_repeat_count <= w_data_q[`CAB_CRIT_LSB +: 3];
      event_repeat_count <= w_data_q[`CAB_EVENT_LSB +: 3];
    end
  end

  // output mode and hysteresis
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alert_mode <= cab_pkg::CAB_MODE_INTERRUPT;
      hysteresis <= `CAB_RST_HYSTERESIS;
    end
    else if (ce && wr_lane0)
    begin
      if (aw_addr_q == `CAB_ADDR_MODE_CTRL)
        alert_mode <= cab_pkg::cab_alert_mode_t'(w_data_q[0]);
      if (aw_addr_q == `CAB_ADDR_HYSTERESIS)
        hysteresis <= w_data_q[7:0];
    end
  end

  // ext1 compensation: factor writes only land with autodetect off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext1_factor_autodetect_on <= 1'(`CAB_RST_EXT1_COMP >> `CAB_AUTO_BIT);
      ext1_compensation_factor_setting <= 3'(`CAB_RST_EXT1_COMP);
    end
    else if (ce)
    begin
      if (wr_lane0 && aw_addr_q == `CAB_ADDR_EXT1_COMP)
      begin
        ext1_factor_autodetect_on <= w_data_q[`CAB_AUTO_BIT];
        if (!w_data_q[`CAB_AUTO_BIT])
          ext1_compensation_factor_setting <= w_data_q[2:0];
      end
      else if (meas_start && ext1_factor_autodetect_on)
        ext1_compensation_factor_setting <= ext1_auto_factor;
    end
  end

  // ext2 compensation, same behaviour
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext2_factor_autodetect_on <= 1'(`CAB_RST_EXT2_COMP >> `CAB_AUTO_BIT);
      ext2_compensation_factor_setting <= 3'(`CAB_RST_EXT2_COMP);
    end
    else if (ce)
    begin
      if (wr_lane0 && aw_addr_q == `CAB_ADDR_EXT2_COMP)
      begin
        ext2_factor_autodetect_on <= w_data_q[`CAB_AUTO_BIT];
        if (!w_data_q[`CAB_AUTO_BIT])
          ext2_compensation_factor_setting <= w_data_q[2:0];
      end
      else if (meas_start && ext2_factor_autodetect_on)
        ext2_compensation_factor_setting <= ext2_auto_factor;
    end
  end

  // setting in use toward the analog front end; 7 with auto off disables
  assign ext1_comp_setting = {ext1_factor_autodetect_on, ext1_compensation_factor_setting};
  assign ext2_comp_setting = {ext2_factor_autodetect_on, ext2_compensation_factor_setting};

  // ----------------------------------------------------------------------
  // per-channel qualification
  // ----------------------------------------------------------------------

  // one counter pair per channel, all sharing the decoded counts
  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    cab_chan_qual u_qual (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .meas_done(meas_done),
      .mode(alert_mode),
      .temp(ch_temp[c*8 +: 8]),
      .high_limit(ch_high_limit[c*8 +: 8]),
      .low_limit(ch_low_limit[c*8 +: 8]),
      .crit_limit(ch_crit_limit[c*8 +: 8]),
      .fault(ch_fault[c]),
      .hysteresis(hysteresis),
      .event_need(count_decode(event_repeat_count)),
      .crit_need(count_decode(critical_repeat_count)),
      .ev_fire(ev_fire[c]),
      .ev_over(ev_over[c]),
      .ev_under(ev_under[c]),
      .ev_fault(ev_fault[c]),
      .ev_held(ev_held[c]),
      .crit_held(crit_held[c])
    );
  end

  // ----------------------------------------------------------------------
  // status and event pins
  // ----------------------------------------------------------------------

  // sticky status, write-one-to-clear, a new event beats the clear
  always_comb
  begin
    next_stat_over = stat_over;
    next_stat_under = stat_under;
    next_stat_fault = stat_fault;
    if (wr_lane0 || (do_write && |w_strb_q))
    begin
      if (aw_addr_q == `CAB_ADDR_STATUS)
      begin
        next_stat_over = stat_over & ~NCH'(w_data_q[`CAB_STAT_OVER_LSB +: NCH] &
                                          lane_mask[`CAB_STAT_OVER_LSB +: NCH]);
        next_stat_under = stat_under & ~NCH'(w_data_q[`CAB_STAT_UNDER_LSB +: NCH] &
                                            lane_mask[`CAB_STAT_UNDER_LSB +: NCH]);
        next_stat_fault = stat_fault & ~NCH'(w_data_q[`CAB_STAT_FAULT_LSB +: NCH] &
                                            lane_mask[`CAB_STAT_FAULT_LSB +: NCH]);
      end
    end
    next_stat_over = next_stat_over | (ev_fire & ev_over);
    next_stat_under = next_stat_under | (ev_fire & ev_under);
    next_stat_fault = next_stat_fault | (ev_fire & ev_fault);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_over <= '0;
      stat_under <= '0;
      stat_fault <= '0;
    end
    else if (ce)
    begin
      stat_over <= next_stat_over;
      stat_under <= next_stat_under;
      stat_fault <= next_stat_fault;
    end
  end

  // event pin: sticky status in interrupt mode, held counters otherwise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alert_n <= 1'b1;
      crit_n <= 1'b1;
    end
    else if (ce)
    begin
      if (alert_mode == cab_pkg::CAB_MODE_COMPARATOR)
        alert_n <= !(|ev_held);
      else
        alert_n <= !(|{next_stat_over, next_stat_under, next_stat_fault});
      crit_n <= !(|crit_held);
    end
  end

  // ----------------------------------------------------------------------
  // bus stall timeout
  // ----------------------------------------------------------------------
  logic smclk_s1;
  logic smclk_s2;
  logic smclk_s3;
  logic [TW-1:0] low_cnt;

  // three-stage synchroniser on the serial clock pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      smclk_s1 <= 1'b1;
      smclk_s2 <= 1'b1;
      smclk_s3 <= 1'b1;
    end
    else if (ce)
    begin
      smclk_s1 <= smclk_pin;
      smclk_s2 <= smclk_s1;
      smclk_s3 <= smclk_s2;
    end
  end

  // counts low time; one reset pulse once low outlasts the limit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_cnt <= '0;
      smbus_proto_reset <= 1'b0;
    end
    else if (ce)
    begin
      smbus_proto_reset <= 1'b0;
      if (!timeout_en || smclk_s2 || smclk_s3)
        low_cnt <= '0;
      else if (low_cnt < TW'(TIMEOUT_CYCLES))
        low_cnt <= low_cnt + TW'(1);
      else if (low_cnt == TW'(TIMEOUT_CYCLES))
      begin
        smbus_proto_reset <= 1'b1;
        low_cnt <= low_cnt + TW'(1);
      end
    end
  end

endmodule : cab_top

`default_nettype wire

// [dv/cab_top_asserts.sv]
/* Checker on cab_top ports.
   Assumes ce high; bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module cab_top_asserts (
  input wire logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic arvalid, arready, rvalid, meas_done, smclk_pin, smbus_proto_reset,
  input wire logic alert_n, crit_n
);
  // ---------------------------------------------------------------
  // properties, all on aclk, quiet in reset
  // ---------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_wr: assert property (p_wr) else $error("late write answer");
  property p_rd; arvalid && arready |=> rvalid && !arready; endproperty
  a_rd: assert property (p_rd) else $error("late read answer");
  property p_bblk; bvalid |-> !awready && !wready; endproperty
  a_bblk: assert property (p_bblk) else $error("write taken early");
  property p_bdrop; bvalid && bready |=> !bvalid; endproperty
  a_bdrop: assert property (p_bdrop) else $error("answer kept");
  property p_alert; $fell(alert_n) |-> $past(meas_done, 2); endproperty
  a_alert: assert property (p_alert) else $error("stray event pin");
  property p_crit; $fell(crit_n) |-> $past(meas_done, 2); endproperty
  a_crit: assert property (p_crit) else $error("stray crit pin");
  property p_crel; $rose(crit_n) |-> $past(meas_done, 2); endproperty
  a_crel: assert property (p_crel) else $error("stray crit release");
  property p_to; smbus_proto_reset |-> !$past(smclk_pin, 8) ##1 !smbus_proto_reset; endproperty
  a_to: assert property (p_to) else $error("stray stall reset");
endmodule : cab_top_asserts
bind cab_top cab_top_asserts u_cab_top_asserts (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .meas_done, .smclk_pin,
  .smbus_proto_reset, .alert_n, .crit_n);
`default_nettype wire

// [dv/cab_smclk_host.sv]
/* Host serial clock: pulled up, low for low_len cycles after go.
   Assumes the block's clock. */
`timescale 1ns/1ps
`default_nettype none
module cab_smclk_host (
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] low_len,
  output logic smclk_pin
);
  logic [7:0] left = 8'h00;
  // count down the stretched low phase
  always_ff @(posedge aclk)
    left <= go ? low_len : left - 8'(left != 8'h00);
  assign smclk_pin = (left == 8'h00);
endmodule : cab_smclk_host
`default_nettype wire

// [dv/test_consecutive_alert_beta_config.sv]
/* Bench for cab_top: register rows, then hand tests.
   Assumes checker and clock host compiled too. */
`timescale 1ns/1ps
`default_nettype none
module test_consecutive_alert_beta_config;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} cab_row_t;
  logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, meas_start = 0, meas_done = 0, go = 0, smclk_pin, smbus_proto_reset;
  logic awready, wready, bvalid, arready, rvalid, alert_n, crit_n;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [2:0] awprot = '0, arprot = '0, ext1_auto_factor = '0, ext2_auto_factor = '0;
  logic [3:0] wstrb = 4'hf, ext1_comp_setting, ext2_comp_setting;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] wdata = '0, rdata, rd;
  logic [23:0] ch_temp = 24'h505050, ch_high_limit = 24'h606060;
  logic [23:0] ch_low_limit = 24'h101010, ch_crit_limit = 24'hffffff;
  logic [2:0] ch_fault = '0;
  int n_fail = 0, checks_done = 0, cyc = 0, n_to = 0;
  cab_row_t rows [5] = '{'{12'h088, 32'hff, 32'hfe, 2'h0}, '{12'h098, 32'hf7, 32'h07, 2'h0},
    '{12'h094, 32'h05, 32'h05, 2'h0}, '{12'h0fc, 32'h01, 32'h00, 2'h2},
    '{12'h104, 32'h0a, 32'h0a, 2'h0}};
  cab_top #(.NCH(3), .TIMEOUT_CYCLES(20)) u_cab_top (.aclk, .aresetn, .ce, .awaddr, .awprot,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .meas_start, .meas_done,
    .ch_temp, .ch_high_limit, .ch_low_limit, .ch_crit_limit, .ch_fault, .ext1_auto_factor,
    .ext2_auto_factor, .smclk_pin, .smbus_proto_reset, .alert_n, .crit_n, .ext1_comp_setting,
    .ext2_comp_setting);
  cab_smclk_host u_cab_smclk_host (.aclk, .go, .low_len(8'h28), .smclk_pin);
  // clock, hang guard, pulse count
  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    n_to += int'(smbus_proto_reset);
    if (cyc == 5000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do @(posedge aclk); while (!awready);
    {awvalid, wvalid} <= '0;
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    rs = bresp;
  endtask : wr
  task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    {rd, rs} = {rdata, rresp};
    rready <= 0;
  endtask : rd_reg
  task automatic meas(input logic [23:0] t, input logic [2:0] f);
    @(posedge aclk);
    {ch_temp, ch_fault, meas_start, meas_done} <= {t, f, 2'h3};
    @(posedge aclk);
    {meas_start, meas_done} <= '0;
    repeat (3) @(posedge aclk);
  endtask : meas
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  // main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd_reg(12'h088); chk(rd, 32'h70);
    rd_reg(12'h094); chk(rd, 32'h08);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d); chk(rs, rows[i].r);
      rd_reg(rows[i].a); chk(rd, rows[i].e); chk(rs, rows[i].r);
    end
    chk(ext2_comp_setting, 4'h7); chk(ext1_comp_setting, 4'h5);
    wr(12'h088, 32'h12);
    meas(24'h505065, 0); chk(alert_n, 1);
    meas(24'h505050, 0); meas(24'h505065, 0); chk(alert_n, 1);
    meas(24'h505050, 3'h1); chk(alert_n, 0);
    wr(12'h108, 32'hffffff); meas(24'h505050, 0); chk(alert_n, 1);
    ch_crit_limit <= 24'h727272;
    meas(24'h505075, 0); meas(24'h755050, 0); chk(crit_n, 1);
    meas(24'h725050, 0); meas(24'h755050, 0); chk(crit_n, 1);
    meas(24'h755050, 0); chk(crit_n, 0);
    meas(24'h6c5050, 0); chk(crit_n, 0);
    meas(24'h605050, 0); chk(crit_n, 1);
    wr(12'h108, 32'hffffff); wr(12'h100, 32'h1); wr(12'h088, 32'h00);
    ch_high_limit <= 24'h585858;
    meas(24'h505005, 3'h7); chk(alert_n, 1);
    meas(24'h505065, 0); chk(alert_n, 0);
    meas(24'h505050, 0); chk(alert_n, 0);
    meas(24'h50504c, 0); chk(alert_n, 1);
    {ext1_auto_factor, ext2_auto_factor} <= 6'h1b;
    wr(12'h094, 32'h08); meas(24'h505050, 0);
    rd_reg(12'h094); chk(rd, 32'h0b);
    wr(12'h094, 32'h0d); rd_reg(12'h094); chk(rd, 32'h0b);
    chk(ext2_comp_setting, 4'h7);
    for (int k = 0; k < 2; k++)
    begin
      wr(12'h088, {24'h0, k[0], 7'h00});
      go <= 1;
      @(posedge aclk) go <= 0;
      repeat (60) @(posedge aclk);
      chk(n_to, k);
    end
    aresetn <= 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd_reg(12'h088); chk(rd, 32'h70);
    summarize();
  end
endmodule : test_consecutive_alert_beta_config
`default_nettype wire
